// [sbmr_map.svh]
// Purpose: Offsets, field positions, reset values and counts of the switch buffer monitor.
// Assumes: Registers sit at their printed offsets on a plain byte-address port.
// Notes: Port registers are at the port base plus a per-port stride.
`ifndef SBMR_MAP_SVH
`define SBMR_MAP_SVH
`define SBMR_ADDR_W 16
`define SBMR_OFF_CHIP_ID3 16'h0003
`define SBMR_OFF_LUE_CTRL0 16'h0310
`define SBMR_OFF_FREE_BLK 16'h03AC
`define SBMR_OFF_IRQ_STAT 16'h0020
`define SBMR_OFF_IRQ_MASK 16'h0024
`define SBMR_OFF_DUPLEX 16'h0028
`define SBMR_PORT_BASE 16'h1000
`define SBMR_PORT_STRIDE 16'h1000
`define SBMR_POFF_TAG_LO 16'h0000
`define SBMR_POFF_TAG_HI 16'h0001
`define SBMR_POFF_TXQ_USED 16'h0A10
`define SBMR_POFF_RX_DROP 16'h0A20
`define SBMR_POFF_TX_DROP 16'h0A24
`define SBMR_POFF_TX_UCAST 16'h0A28
`define SBMR_FREE_LSB 16
`define SBMR_SRST_BIT 0
`define SBMR_VLAN_EN_BIT 7
`define SBMR_FREE_RESET 11'h7E8
`define SBMR_BLK_W 11
`define SBMR_IRQ_RXDROP 0
`define SBMR_IRQ_TXDROP 1
`endif

// [sbmr_pkg.sv]
// Purpose: Types shared by the switch buffer monitor.
// Assumes: Nothing beyond the map header.
// Notes: The bus struct carries one request per cycle.
`include "sbmr_map.svh"
package sbmr_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sbmr_bus_t;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} sbmr_speed_t;
  typedef enum {SRST_IDLE, SRST_ARMED} sbmr_srst_t;
endpackage

// [sbmr_top.sv]
// Function
// - Free packet-memory block count reads in bits 26:16 of the global register.
// - Each port's occupied transmit-queue block count reads in bits 10:0.
// - Idle switch reads free count 0x7e8 and zero used blocks everywhere.
// - Separate receive-drop and transmit-drop counters per port, readable by software.
// - Forward to a full transmit queue drops it and counts a transmit drop.
// - No free memory drops each received packet, counting a receive drop.
// - With memory exhausted all ports drop received packets until blocks free.
// - One full transmit queue does not stop forwarding to other ports.
// - Unicast transmit counter counts unicast frames and pause frames sent.
// - Pause frames transmit independently of a stalled data queue.
// - VLAN enable bit in lookup control; cleared, VLAN lookup is bypassed.
// - Half duplex only at 10 and 100 megabit; gigabit always full duplex.
// - Setting then clearing the software reset bit performs a software reset.
// - Software reset clears VLAN table and default tags, keeps other settings.
// - Hardware reset pin returns everything to initial state.
// Purpose: Buffer accounting, drop counters and recovery of a multi-port switch.
// Assumes: One block per packet; one receive and one transmit event per port per cycle.
// Notes: Receive and transmit events come from logic on sys_clk.
`timescale 1ns/1ps
`include "sbmr_map.svh"
module sbmr_top #(
  parameter int NPORTS = 7,
  parameter int TXQ_DEPTH = 1024,
  parameter int VLAN_ENTRIES = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sbmr_pkg::sbmr_bus_t bus,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic [NPORTS-1:0] rx_pkt,
  input wire logic [NPORTS-1:0] rx_unicast,
  input wire logic [NPORTS*3-1:0] rx_dest,
  input wire logic [NPORTS-1:0] tx_done,
  input wire logic [NPORTS-1:0] pause_req,
  input wire sbmr_pkg::sbmr_speed_t [NPORTS-1:0] link_speed,
  output logic [NPORTS-1:0] fwd_pkt,
  output logic [NPORTS-1:0] pause_tx,
  output logic [NPORTS-1:0] half_duplex,
  output logic vlan_lookup_en,
  output logic soft_reset
);
  import sbmr_pkg::*;
  localparam int BW = `SBMR_BLK_W;
  localparam int PW = $clog2(NPORTS) > 0 ? $clog2(NPORTS) : 1;
  localparam int CW = $clog2(NPORTS + 1);

  logic [BW-1:0] free_q;
  logic [BW-1:0] used_q [NPORTS];
  logic [31:0] rxd_q [NPORTS];
  logic [31:0] txd_q [NPORTS];
  logic [31:0] uc_q [NPORTS];
  logic [7:0] tag_lo_q [NPORTS];
  logic [7:0] tag_hi_q [NPORTS];
  logic [11:0] vlan_tab_q [VLAN_ENTRIES];
  logic [7:0] lue_q;
  logic [7:0] chip3_q;
  logic [NPORTS-1:0] hd_req_q;
  logic [1:0] istat_q;
  logic [1:0] imask_q;
  sbmr_srst_t srst_q;
  logic srst_pulse;

  logic [NPORTS-1:0] txq_full;
  logic [NPORTS-1:0] acc;
  logic [NPORTS-1:0] drop_tx;
  logic [NPORTS-1:0] drop_rx;
  logic [NPORTS-1:0] rel;
  logic [BW-1:0] n_alloc;
  logic [BW-1:0] n_rel;
  logic [CW-1:0] txd_n [NPORTS];

  logic wr_global;
  logic [PW-1:0] port_idx;
  logic [15:0] poff;
  logic port_hit;

  assign poff = (bus.addr - `SBMR_PORT_BASE) & (`SBMR_PORT_STRIDE - 16'h0001);
  assign port_idx = PW'((bus.addr - `SBMR_PORT_BASE) / `SBMR_PORT_STRIDE);
  assign port_hit = (bus.addr >= `SBMR_PORT_BASE) &&
                    (((bus.addr - `SBMR_PORT_BASE) / `SBMR_PORT_STRIDE) < 16'(NPORTS));
  assign wr_global = bus.wr && !port_hit;

  // Admission: a packet is dropped entirely when memory is empty, else per destination.
  always_comb begin
    acc = '0;
    drop_tx = '0;
    drop_rx = '0;
    n_alloc = '0;
    n_rel = '0;
    txq_full = '0;
    rel = '0;
    for (int p = 0; p < NPORTS; p++) begin
      txd_n[p] = '0;
    end
    for (int p = 0; p < NPORTS; p++) begin
      txq_full[p] = (used_q[p] >= BW'(TXQ_DEPTH));
      rel[p] = tx_done[p] && (used_q[p] != '0);
      if (rel[p]) begin
        n_rel = n_rel + BW'(1);
      end
    end
    // Every dropped packet is counted, even several to one port in a cycle.
    for (int p = 0; p < NPORTS; p++) begin
      if (rx_pkt[p]) begin
        if (free_q <= n_alloc) begin
          drop_rx[p] = 1'b1;
        end else if (txq_full[rx_dest[p*3 +: 3]]) begin
          drop_tx[rx_dest[p*3 +: 3]] = 1'b1;
          txd_n[rx_dest[p*3 +: 3]] = txd_n[rx_dest[p*3 +: 3]] + CW'(1);
        end else if (!acc[rx_dest[p*3 +: 3]]) begin
          acc[rx_dest[p*3 +: 3]] = 1'b1;
          n_alloc = n_alloc + BW'(1);
        end else begin
          drop_tx[rx_dest[p*3 +: 3]] = 1'b1;
          txd_n[rx_dest[p*3 +: 3]] = txd_n[rx_dest[p*3 +: 3]] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      free_q <= `SBMR_FREE_RESET;
    end else begin
      free_q <= free_q - n_alloc + n_rel;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          used_q[g] <= '0;
        end else begin
          used_q[g] <= used_q[g] + BW'(acc[g]) - BW'(rel[g]);
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          rxd_q[g] <= '0;
        end else if (drop_rx[g]) begin
          rxd_q[g] <= rxd_q[g] + 32'h00000001;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          txd_q[g] <= '0;
        end else if (drop_tx[g]) begin
          txd_q[g] <= txd_q[g] + 32'(txd_n[g]);
        end
      end
      // A real departure and a pause frame in one cycle are two frames.
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          uc_q[g] <= '0;
        end else begin
          uc_q[g] <= uc_q[g] + 32'(rel[g] && rx_unicast[g]) + 32'(pause_req[g]);
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          tag_lo_q[g] <= '0;
          tag_hi_q[g] <= '0;
        end else if (srst_pulse) begin
          tag_lo_q[g] <= '0;
          tag_hi_q[g] <= '0;
        end else if (bus.wr && port_hit && port_idx == PW'(g)) begin
          if (poff == `SBMR_POFF_TAG_LO) begin
            tag_lo_q[g] <= bus.wdata[7:0];
          end
          if (poff == `SBMR_POFF_TAG_HI) begin
            tag_hi_q[g] <= bus.wdata[7:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < VLAN_ENTRIES; i++) begin
        vlan_tab_q[i] <= '0;
      end
    end else if (srst_pulse) begin
      for (int i = 0; i < VLAN_ENTRIES; i++) begin
        vlan_tab_q[i] <= '0;
      end
    end else if (acc[0] && vlan_lookup_en) begin
      vlan_tab_q[tag_lo_q[0][3:0]] <= {tag_hi_q[0][3:0], tag_lo_q[0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip3_q <= '0;
    end else if (wr_global && bus.addr == `SBMR_OFF_CHIP_ID3) begin
      chip3_q <= bus.wdata[7:0];
    end
  end

  // Software reset fires on the clearing write that follows a setting write.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_q <= SRST_IDLE;
      srst_pulse <= 1'b0;
    end else begin
      srst_pulse <= 1'b0;
      if (wr_global && bus.addr == `SBMR_OFF_CHIP_ID3) begin
        case (srst_q)
          SRST_IDLE: begin
            if (bus.wdata[`SBMR_SRST_BIT]) begin
              srst_q <= SRST_ARMED;
            end
          end
          SRST_ARMED: begin
            if (!bus.wdata[`SBMR_SRST_BIT]) begin
              srst_q <= SRST_IDLE;
              srst_pulse <= 1'b1;
            end
          end
          default: begin
            srst_q <= SRST_IDLE;
          end
        endcase
      end
    end
  end

  // Lookup control survives a software reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lue_q <= '0;
    end else if (wr_global && bus.addr == `SBMR_OFF_LUE_CTRL0) begin
      lue_q <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hd_req_q <= '0;
    end else if (wr_global && bus.addr == `SBMR_OFF_DUPLEX) begin
      hd_req_q <= bus.wdata[NPORTS-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imask_q <= '0;
    end else if (wr_global && bus.addr == `SBMR_OFF_IRQ_MASK) begin
      imask_q <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_q <= '0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (b == `SBMR_IRQ_RXDROP ? |drop_rx : |drop_tx) begin
          istat_q[b] <= 1'b1;
        end else if (wr_global && bus.addr == `SBMR_OFF_IRQ_STAT && bus.wdata[b]) begin
          istat_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_pkt <= '0;
    end else begin
      fwd_pkt <= acc;
    end
  end

  // Pause frames bypass the data queues, so a stalled queue cannot hold them.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_tx <= '0;
    end else begin
      pause_tx <= pause_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_duplex <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        half_duplex[p] <= hd_req_q[p] && (link_speed[p] != SPD_1000);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vlan_lookup_en <= 1'b0;
    end else begin
      vlan_lookup_en <= lue_q[`SBMR_VLAN_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= srst_pulse;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_q & imask_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (bus.rd && port_hit) begin
        case (poff)
          `SBMR_POFF_TAG_LO: rdata <= {24'h000000, tag_lo_q[port_idx]};
          `SBMR_POFF_TAG_HI: rdata <= {24'h000000, tag_hi_q[port_idx]};
          `SBMR_POFF_TXQ_USED: rdata <= {21'h000000, used_q[port_idx]};
          `SBMR_POFF_RX_DROP: rdata <= rxd_q[port_idx];
          `SBMR_POFF_TX_DROP: rdata <= txd_q[port_idx];
          `SBMR_POFF_TX_UCAST: rdata <= uc_q[port_idx];
          default: rdata <= '0;
        endcase
      end else if (bus.rd) begin
        case (bus.addr)
          `SBMR_OFF_CHIP_ID3: rdata <= {24'h000000, chip3_q};
          `SBMR_OFF_LUE_CTRL0: rdata <= {24'h000000, lue_q};
          `SBMR_OFF_FREE_BLK: rdata <= {5'h00, free_q, 16'h0000};
          `SBMR_OFF_IRQ_STAT: rdata <= {30'h00000000, istat_q};
          `SBMR_OFF_IRQ_MASK: rdata <= {30'h00000000, imask_q};
          `SBMR_OFF_DUPLEX: rdata <= 32'(hd_req_q);
          default: rdata <= '0;
        endcase
      end
    end
  end
endmodule

// [sbmr_properties.sv]
// Purpose: Port-level checks of the switch buffer monitor.
// Assumes: One clock domain, reset active low.
// Notes: Bound into every sbmr_top instance.
`timescale 1ns/1ps
`include "sbmr_map.svh"
module sbmr_properties #(
  parameter int NPORTS = 7
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sbmr_pkg::sbmr_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic [NPORTS-1:0] rx_pkt,
  input wire sbmr_pkg::sbmr_speed_t [NPORTS-1:0] link_speed,
  input wire logic [NPORTS-1:0] fwd_pkt,
  input wire logic [NPORTS-1:0] pause_req,
  input wire logic [NPORTS-1:0] pause_tx,
  input wire logic [NPORTS-1:0] half_duplex,
  input wire logic vlan_lookup_en,
  input wire logic soft_reset
);
  import sbmr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [NPORTS-1:0] gig;
  logic vl_wr;
  logic clr_wr;
  int rx_cnt;
  always_comb for (int i = 0; i < NPORTS; i++) gig[i] = (link_speed[i] == SPD_1000);
  assign vl_wr = bus.wr && bus.addr == `SBMR_OFF_LUE_CTRL0;
  assign clr_wr = bus.wr && bus.addr == `SBMR_OFF_CHIP_ID3 && !bus.wdata[0];
  assign rx_cnt = $countones(rx_pkt);
  sequence s_arm;
    bus.wr && bus.addr == `SBMR_OFF_CHIP_ID3 && bus.wdata[0];
  endsequence
  sequence s_clr;
    clr_wr;
  endsequence
  chk_pause_passes: assert property ($past(rst_n) |-> pause_tx == $past(pause_req))
    else $error("pause frame not passed on");
  chk_gig_full: assert property ($past(rst_n) |-> (half_duplex & $past(gig)) == '0)
    else $error("half duplex at gigabit");
  chk_free_format: assert property ($past(bus.rd) && $past(bus.addr) == `SBMR_OFF_FREE_BLK
    |-> rdata[31:27] == 5'h0 && rdata[15:0] == 16'h0)
    else $error("free count outside its field");
  chk_srst_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  chk_srst_sequence: assert property (s_arm ##1 s_clr |=> ##1 soft_reset)
    else $error("soft reset missing after set then clear");
  chk_srst_cause: assert property (soft_reset |-> $past(clr_wr, 2))
    else $error("soft reset without clearing write");
  chk_vlan_cause: assert property ($changed(vlan_lookup_en) |-> $past(vl_wr, 2))
    else $error("vlan enable changed without write");
  chk_fwd_cause: assert property (fwd_pkt != '0 |-> $past(rx_pkt) != '0)
    else $error("forward without received packet");
  chk_fwd_count: assert property ($countones(fwd_pkt) <= $past(rx_cnt))
    else $error("more forwards than packets");
endmodule
bind sbmr_top sbmr_properties #(.NPORTS(NPORTS)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .bus(bus), .rdata(rdata), .rx_pkt(rx_pkt), .link_speed(link_speed), .fwd_pkt(fwd_pkt),
  .pause_req(pause_req), .pause_tx(pause_tx), .half_duplex(half_duplex),
  .vlan_lookup_en(vlan_lookup_en), .soft_reset(soft_reset));

// [sbmr_link_partner.sv]
// Purpose: Ethernet link partners on all switch ports.
// Assumes: Mode 1 one hot spot, 2 drain, 3 pause, 4 spread traffic.
// Notes: Drains may hit empty queues on purpose.
`timescale 1ns/1ps
module sbmr_link_partner #(
  parameter int NPORTS = 7
) (
  input wire logic sys_clk,
  input wire logic [2:0] mode,
  output logic [NPORTS-1:0] rx_pkt,
  output logic [NPORTS-1:0] rx_unicast,
  output logic [NPORTS*3-1:0] rx_dest,
  output logic [NPORTS-1:0] tx_done,
  output logic [NPORTS-1:0] pause_req,
  output sbmr_pkg::sbmr_speed_t [NPORTS-1:0] link_speed
);
  import sbmr_pkg::*;
  int seed = 59411;
  int k = 0;
  initial begin
    {rx_pkt, rx_unicast, rx_dest, tx_done, pause_req} = '0;
    for (int p = 0; p < NPORTS; p++) link_speed[p] = sbmr_speed_t'(p % 3);
  end
  always @(posedge sys_clk) begin
    k <= k + 1;
    rx_pkt <= (mode == 3'h1 || mode == 3'h4) ? NPORTS'($random(seed)) : '0;
    tx_done <= (mode == 3'h2) ? NPORTS'($random(seed)) : '0;
    pause_req <= (mode == 3'h3) ? NPORTS'($random(seed)) : '0;
    rx_unicast <= NPORTS'($random(seed));
    for (int p = 0; p < NPORTS; p++) begin
      rx_dest[p*3+:3] <= (mode == 3'h4) ? 3'((p + k) % NPORTS) : (p == 3 ? 3'h4 : 3'h2);
    end
  end
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench of the buffer monitor.
// Assumes: Counters are read only while traffic is quiet.
// Notes: Queue depth is shortened to 512 blocks.
`timescale 1ns/1ps
`include "sbmr_map.svh"
module tb_top;
  import sbmr_pkg::*;
  localparam int N = 7;
  localparam int D = 512;
  logic sys_clk = 0;
  logic rst_n = 0;
  sbmr_bus_t bus = '0;
  logic [2:0] mode = 3'h0;
  logic [31:0] rdata;
  logic irq, vlan_lookup_en, soft_reset;
  logic [N-1:0] rx_pkt, rx_unicast, tx_done, pause_req, fwd_pkt, pause_tx, half_duplex;
  logic [N*3-1:0] rx_dest;
  sbmr_speed_t [N-1:0] link_speed;
  logic [N-1:0] taken;
  int fails = 0;
  int comparisons = 0;
  int free_m, d;
  int used_m[N], rxd_m[N], txd_m[N], uc_m[N];
  always #4 sys_clk = ~sys_clk;
  sbmr_top #(.NPORTS(N), .TXQ_DEPTH(D)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .irq(irq), .rx_pkt(rx_pkt), .rx_unicast(rx_unicast), .rx_dest(rx_dest),
    .tx_done(tx_done), .pause_req(pause_req), .link_speed(link_speed), .fwd_pkt(fwd_pkt),
    .pause_tx(pause_tx), .half_duplex(half_duplex), .vlan_lookup_en(vlan_lookup_en),
    .soft_reset(soft_reset));
  sbmr_link_partner #(.NPORTS(N)) lp_u (.sys_clk(sys_clk), .mode(mode), .rx_pkt(rx_pkt),
    .rx_unicast(rx_unicast), .rx_dest(rx_dest), .tx_done(tx_done), .pause_req(pause_req),
    .link_speed(link_speed));
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      free_m = 32'h000007E8;
      foreach (used_m[p]) {used_m[p], rxd_m[p], txd_m[p], uc_m[p]} = '0;
    end else begin
      taken = '0;
      for (int p = 0; p < N; p++) if (rx_pkt[p]) begin
        d = rx_dest[p*3+:3];
        if (free_m == 0) rxd_m[p]++;
        else if (used_m[d] >= D || taken[d]) txd_m[d]++;
        else begin
          used_m[d]++;
          free_m--;
          taken[d] = 1'b1;
        end
      end
      for (int p = 0; p < N; p++) begin
        if (tx_done[p] && used_m[p] > 0) begin
          used_m[p]--;
          free_m++;
          uc_m[p] += int'(rx_unicast[p]);
        end
        uc_m[p] += int'(pause_req[p]);
      end
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] w);
    @(posedge sys_clk) bus <= '{a, w, 1'b1, 1'b0};
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk) bus <= '0;
    @(negedge sys_clk) cmp(rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk) bus <= '0;
  endtask
  function automatic logic [15:0] pa(input int p, input logic [15:0] o);
    return 16'(16'h1000 * (p + 1)) + o;
  endfunction
  task automatic check_all;
    rd(`SBMR_OFF_FREE_BLK, {5'h0, 11'(free_m), 16'h0});
    for (int p = 0; p < N; p++) begin
      rd(pa(p, `SBMR_POFF_TXQ_USED), 32'(used_m[p]));
      rd(pa(p, `SBMR_POFF_RX_DROP), 32'(rxd_m[p]));
      rd(pa(p, `SBMR_POFF_TX_DROP), 32'(txd_m[p]));
      rd(pa(p, `SBMR_POFF_TX_UCAST), 32'(uc_m[p]));
    end
  endtask
  task automatic run(input logic [2:0] m, input int n);
    @(posedge sys_clk) mode <= m;
    cyc(n);
    mode <= 3'h0;
    cyc(4);
  endtask
  task automatic complete_run;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #80000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    check_all;
    rd(16'h0FF0, 32'h0);
    run(3'h1, 700);
    check_all;
    rd(`SBMR_OFF_IRQ_STAT, 32'h2);
    wr(`SBMR_OFF_IRQ_MASK, 32'h2);
    cyc(3);
    cmp({31'h0, irq}, 32'h1);
    wr(`SBMR_OFF_IRQ_MASK, 32'h0);
    cyc(3);
    cmp({31'h0, irq}, 32'h0);
    wr(`SBMR_OFF_IRQ_STAT, 32'h2);
    rd(`SBMR_OFF_IRQ_STAT, 32'h0);
    run(3'h2, 300);
    run(3'h3, 50);
    check_all;
    run(3'h4, 900);
    check_all;
    cmp(32'(free_m <= 32'h00000580), 32'h00000001);
    run(3'h2, 100);
    run(3'h1, 20);
    check_all;
    wr(`SBMR_OFF_LUE_CTRL0, 32'h80);
    wr(pa(1, `SBMR_POFF_TAG_LO), 32'h5A);
    wr(pa(1, `SBMR_POFF_TAG_HI), 32'hA5);
    cyc(3);
    cmp({31'h0, vlan_lookup_en}, 32'h1);
    rd(pa(1, `SBMR_POFF_TAG_HI), 32'hA5);
    wr(`SBMR_OFF_CHIP_ID3, 32'h1);
    wr(`SBMR_OFF_CHIP_ID3, 32'h0);
    cyc(4);
    rd(pa(1, `SBMR_POFF_TAG_LO), 32'h0);
    rd(pa(1, `SBMR_POFF_TAG_HI), 32'h0);
    rd(`SBMR_OFF_LUE_CTRL0, 32'h80);
    wr(`SBMR_OFF_LUE_CTRL0, 32'h0);
    cyc(3);
    cmp({31'h0, vlan_lookup_en}, 32'h0);
    wr(`SBMR_OFF_DUPLEX, 32'h7F);
    cyc(3);
    cmp({25'h0, half_duplex}, 32'h5B);
    run(3'h1, 30);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    check_all;
    cmp({25'h0, half_duplex}, 32'h0);
    complete_run;
  end
endmodule
